//--- bus_release_params.svh
// Purpose: Constants for the bus release and snoop control ends
// Assumes: Single 50 MHz clock
// Notes: Widths fixed at documented values
`ifndef BUS_RELEASE_PARAMS_SVH
`define BUS_RELEASE_PARAMS_SVH
`define ADDR_W 28
`define DATA_W 32
`define TAG_W 8
`define LINE_W 2
`define LINES 4
`define IDX_W 2
`define FILL_WORDS 3'h4
`define ZERO_ADDR 28'h0000000
`define ZERO_DATA 32'h00000000
`endif

//--- bus_release_pkg.sv
// Purpose: Shared types for both ends
// Assumes: bus_release_params.svh included
// Notes: Types only
`include "bus_release_params.svh"
package bus_release_pkg;
  typedef logic [`ADDR_W-1:0] addr_t;
  typedef logic [`DATA_W-1:0] data_t;
  typedef enum logic [2:0] {CPU_IDLE, CPU_ADDR, CPU_DATA, CPU_HELD, CPU_BACKOFF} cpu_state_t;
  typedef enum logic [1:0] {SYS_IDLE, SYS_HOLD, SYS_SNOOP} sys_state_t;
endpackage : bus_release_pkg

//--- bus_release_if.sv
// Purpose: Link between processor end and system end
// Assumes: One clock
// Notes: Shared address pins resolved from enables
`timescale 1ns/1ps
`include "bus_release_params.svh"
interface bus_release_if;
  import bus_release_pkg::*;
  logic internalCyclePending;
  logic busSurrenderRequest;
  logic busSurrenderAck;
  logic busBackoff_n;
  logic addressFloatRequest;
  logic snoopAddressStrobe_n;
  logic cacheableCycle_n;
  logic burstWordDone_n;
  logic cycleDone_n;
  logic cacheFlush_n;
  logic cycleStart_n;
  logic burstLast_n;
  logic writeCycle;
  addr_t cpuAddrOut;
  logic cpuAddrOe;
  addr_t sysAddrOut;
  logic sysAddrOe;
  addr_t addr;
  data_t cpuDataOut;
  logic cpuDataOe;
  data_t sysDataOut;
  assign addr = cpuAddrOe ? cpuAddrOut : (sysAddrOe ? sysAddrOut : `ZERO_ADDR);
  modport cpu (output internalCyclePending, busSurrenderAck, cycleStart_n, burstLast_n,
    writeCycle, cpuAddrOut, cpuAddrOe, cpuDataOut, cpuDataOe,
    input busSurrenderRequest, busBackoff_n, addressFloatRequest, snoopAddressStrobe_n,
    cacheableCycle_n, burstWordDone_n, cycleDone_n, cacheFlush_n, addr, sysDataOut);
  modport sys (input internalCyclePending, busSurrenderAck, cycleStart_n, burstLast_n,
    writeCycle, addr, cpuDataOut, cpuDataOe,
    output busSurrenderRequest, busBackoff_n, addressFloatRequest, snoopAddressStrobe_n,
    cacheableCycle_n, burstWordDone_n, cycleDone_n, cacheFlush_n, sysAddrOut, sysAddrOe,
    sysDataOut);
endinterface : bus_release_if

//--- bus_release_cpu.sv
// Purpose: Processor end: bus ownership, back-off, snoop and cache control
// Assumes: All link inputs synchronous except the flush input
// Notes: Small direct-mapped tag store models the internal cache
// Behaviour
// - Pending output follows any internal cycle need
// - Pending output active high, always driven
// - Finish cycle, then float and acknowledge
// - Stay surrendered while request held
// - Acknowledge and float in same clock
// - Acknowledge active high, dropped on leaving
// - Back-off floats pins the next clock
// - Back-off never raises the acknowledge
// - Back-off beats completion in same clock
// - Stay floated while back-off held
// - Interrupted cycle restarts from beginning
// - Address float releases address next clock
// - Address float releases only address lines
// - Snoop strobe invalidates matching cache entry
// - Cacheable input turns cycle into fill
// - Line stored only if cacheable before last
// - Flush invalidates whole cache
// - Flush synchronised before use
// - Completion ignored when idle or first clock
// - Burst words counted from second clock
`timescale 1ns/1ps
`include "bus_release_params.svh"
module bus_release_cpu
  import bus_release_pkg::*;
(
  input wire logic clock,
  input wire logic arst_n,
  bus_release_if.cpu link,
  input wire logic reqValid,
  input wire bus_release_pkg::addr_t reqAddr,
  input wire logic reqWrite,
  input wire logic reqCacheable,
  input wire bus_release_pkg::data_t reqData,
  output logic reqDone,
  output bus_release_pkg::data_t readData,
  output logic cacheHit
);
  import bus_release_pkg::*;

  typedef struct packed {
    cpu_state_t st;
    logic pending;
    logic ack;
    logic addrOe;
    logic dataOe;
    logic start_n;
    logic last_n;
    logic write;
    logic fill;
    logic kenSeen;
    logic restart;
    logic [2:0] words;
    addr_t addr;
    data_t wdata;
    data_t rdata;
    logic done;
    logic hit;
    logic flushMeta;
    logic flushSync;
    logic flushPrev;
    logic [`LINES-1:0] valid;
    logic [`LINES-1:0][`TAG_W-1:0] tag;
  } cpu_regs_t;

  cpu_regs_t r;
  cpu_regs_t next_r;

  function automatic logic [`IDX_W-1:0] lineIndex(input addr_t a);
    lineIndex = a[`IDX_W+`LINE_W-1:`LINE_W];
  endfunction : lineIndex

  function automatic logic [`TAG_W-1:0] lineTag(input addr_t a);
    lineTag = a[`TAG_W+`IDX_W+`LINE_W-1:`IDX_W+`LINE_W];
  endfunction : lineTag

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb
  begin
    logic bus_backoff_n;
    logic ended;
    logic anyDone;
    bus_backoff_n = 1'b0;
    ended = 1'b0;
    anyDone = 1'b0;
    next_r = r;
    next_r.done = 1'b0;
    next_r.start_n = 1'b1;
    bus_backoff_n = !link.busBackoff_n;
    anyDone = !link.cycleDone_n || !link.burstWordDone_n;
    next_r.pending = reqValid || r.restart || (r.st inside {CPU_ADDR, CPU_DATA});
    // Flush input is synchronised first
    next_r.flushMeta = !link.cacheFlush_n;
    next_r.flushSync = r.flushMeta;
    next_r.flushPrev = r.flushSync;
    if (r.flushSync && !r.flushPrev)
    begin
      next_r.valid = '0;
    end
    // Snoop invalidate from externally driven address
    if (!link.snoopAddressStrobe_n && !r.addrOe)
    begin
      if (lineTag(link.addr) == r.tag[lineIndex(link.addr)])
      begin
        next_r.valid[lineIndex(link.addr)] = 1'b0;
      end
    end
    case (r.st)
      CPU_IDLE:
      begin
        if (bus_backoff_n)
        begin
          next_r.st = CPU_BACKOFF;
        end
        else if (link.busSurrenderRequest)
        begin
          next_r.st = CPU_HELD;
          next_r.ack = 1'b1;
          next_r.addrOe = 1'b0;
          next_r.dataOe = 1'b0;
        end
        else if (reqValid || r.restart)
        begin
          if (!r.restart)
          begin
            next_r.addr = reqAddr;
            next_r.write = reqWrite;
            next_r.wdata = reqData;
            next_r.fill = reqCacheable && !reqWrite;
          end
          next_r.restart = 1'b0;
          next_r.st = CPU_ADDR;
          next_r.start_n = 1'b0;
          next_r.words = '0;
          next_r.kenSeen = 1'b0;
          next_r.addrOe = !link.addressFloatRequest;
          next_r.dataOe = next_r.write;
          next_r.last_n = 1'b1;
        end
        else
        begin
          next_r.addrOe = !link.addressFloatRequest;
        end
      end
      CPU_ADDR:
      begin
        // Completion ignored in first clock
        next_r.fill = r.fill && !link.cacheableCycle_n;
        next_r.last_n = !(r.write || !next_r.fill);
        next_r.addrOe = !link.addressFloatRequest;
        if (bus_backoff_n)
        begin
          next_r.st = CPU_BACKOFF;
        end
        else
        begin
          next_r.st = CPU_DATA;
        end
      end
      CPU_DATA:
      begin
        if (bus_backoff_n)
        begin
          next_r.st = CPU_BACKOFF;
        end
        else if (anyDone)
        begin
          next_r.rdata = link.sysDataOut;
          next_r.words = r.words + 3'h1;
          ended = !r.fill || !link.cycleDone_n || (r.words + 3'h1 == `FILL_WORDS);
          if (r.words + 3'h1 == `FILL_WORDS - 3'h1)
          begin
            next_r.last_n = 1'b0;
          end
          if (ended)
          begin
            next_r.st = CPU_IDLE;
            next_r.done = 1'b1;
            next_r.dataOe = 1'b0;
            next_r.last_n = 1'b1;
            if (r.fill && r.kenSeen && (r.words + 3'h1 == `FILL_WORDS))
            begin
              next_r.valid[lineIndex(r.addr)] = 1'b1;
              next_r.tag[lineIndex(r.addr)] = lineTag(r.addr);
            end
          end
        end
        next_r.kenSeen = !link.cacheableCycle_n;
        if (!bus_backoff_n)
        begin
          next_r.addrOe = !link.addressFloatRequest;
        end
      end
      CPU_HELD:
      begin
        if (!link.busSurrenderRequest)
        begin
          next_r.st = CPU_IDLE;
          next_r.ack = 1'b0;
          next_r.addrOe = !link.addressFloatRequest && link.busBackoff_n;
        end
      end
      CPU_BACKOFF:
      begin
        if (link.busBackoff_n)
        begin
          next_r.st = CPU_IDLE;
          next_r.addrOe = !link.addressFloatRequest;
        end
      end
      default:
      begin
        next_r.st = CPU_IDLE;
      end
    endcase
    if (bus_backoff_n && r.st != CPU_HELD && r.st != CPU_BACKOFF)
    begin
      next_r.addrOe = 1'b0;
      next_r.dataOe = 1'b0;
      next_r.last_n = 1'b1;
      next_r.done = 1'b0;
      next_r.restart = r.st inside {CPU_ADDR, CPU_DATA};
    end
    next_r.hit = reqValid && r.valid[lineIndex(reqAddr)]
      && (r.tag[lineIndex(reqAddr)] == lineTag(reqAddr));
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      r <= '{st: CPU_IDLE, start_n: 1'b1, last_n: 1'b1, addrOe: 1'b1, default: '0};
    end
    else
    begin
      r <= next_r;
    end
  end

  assign link.internalCyclePending = r.pending;
  assign link.busSurrenderAck = r.ack;
  assign link.cycleStart_n = r.start_n;
  assign link.burstLast_n = r.last_n;
  assign link.writeCycle = r.write;
  assign link.cpuAddrOut = r.addr;
  assign link.cpuAddrOe = r.addrOe;
  assign link.cpuDataOut = r.wdata;
  assign link.cpuDataOe = r.dataOe;
  assign reqDone = r.done;
  assign readData = r.rdata;
  assign cacheHit = r.hit;
endmodule : bus_release_cpu

//--- bus_release_sys.sv
// Purpose: System end: surrender, back-off, snoop and completion driver
// Assumes: Processor clock and reset
// Notes: snoopGo and flushGo are one-cycle pulses; wantBus and backoffHold are levels
`timescale 1ns/1ps
module bus_release_sys
  import bus_release_pkg::*;
(
  input wire logic clock,
  input wire logic arst_n,
  bus_release_if.sys link,
  input wire logic wantBus,
  input wire logic backoffHold,
  input wire logic snoopGo,
  input wire bus_release_pkg::addr_t snoopAddr,
  input wire logic flushGo,
  input wire logic cacheableMem,
  input wire logic burstMode,
  input wire bus_release_pkg::data_t memData,
  output logic busGranted,
  output logic pendingSeen
);
  import bus_release_pkg::*;

  typedef struct packed {
    sys_state_t st;
    logic hold;
    logic bus_backoff_n_n;
    logic address_float_request;
    logic snoop_address_strobe_n_n;
    logic aOe;
    addr_t a;
    logic rdy_n;
    logic burst_word_done_n_n;
    logic ken_n;
    logic flush_n;
    logic inCycle;
    logic granted;
    logic pend;
    data_t d;
  } sys_regs_t;

  sys_regs_t r;
  sys_regs_t next_r;

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb
  begin
    next_r = r;
    next_r.snoop_address_strobe_n_n = 1'b1;
    next_r.flush_n = !flushGo;
    next_r.hold = wantBus;
    next_r.bus_backoff_n_n = !backoffHold;
    next_r.granted = link.busSurrenderAck;
    next_r.pend = link.internalCyclePending;
    next_r.d = memData;
    next_r.rdy_n = 1'b1;
    next_r.burst_word_done_n_n = 1'b1;
    next_r.ken_n = !cacheableMem;
    if (!link.cycleStart_n)
    begin
      next_r.inCycle = 1'b1;
    end
    else if (r.inCycle)
    begin
      // Completion from second clock of a cycle
      if (burstMode && !link.writeCycle && r.ken_n == 1'b0)
      begin
        next_r.burst_word_done_n_n = 1'b0;
      end
      else
      begin
        next_r.rdy_n = 1'b0;
      end
    end
    if (!r.rdy_n || (!r.burst_word_done_n_n && !link.burstLast_n) || backoffHold)
    begin
      next_r.inCycle = 1'b0;
    end
    case (r.st)
      SYS_IDLE:
      begin
        if (snoopGo)
        begin
          next_r.address_float_request = 1'b1;
          next_r.a = snoopAddr;
          next_r.st = SYS_SNOOP;
        end
      end
      SYS_SNOOP:
      begin
        if (!link.cpuDataOe && next_r.address_float_request && !r.aOe && r.snoop_address_strobe_n_n)
        begin
          next_r.aOe = 1'b1;
        end
        else if (r.aOe && r.snoop_address_strobe_n_n)
        begin
          next_r.snoop_address_strobe_n_n = 1'b0;
        end
        else if (!r.snoop_address_strobe_n_n)
        begin
          next_r.aOe = 1'b0;
          next_r.address_float_request = 1'b0;
          next_r.st = SYS_IDLE;
        end
      end
      default:
      begin
        next_r.st = SYS_IDLE;
      end
    endcase
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      r <= '{st: SYS_IDLE, bus_backoff_n_n: 1'b1, snoop_address_strobe_n_n: 1'b1, rdy_n: 1'b1, burst_word_done_n_n: 1'b1,
        ken_n: 1'b1, flush_n: 1'b1, default: '0};
    end
    else
    begin
      r <= next_r;
    end
  end

  assign link.busSurrenderRequest = r.hold;
  assign link.busBackoff_n = r.bus_backoff_n_n;
  assign link.addressFloatRequest = r.address_float_request;
  assign link.snoopAddressStrobe_n = r.snoop_address_strobe_n_n;
  assign link.cacheableCycle_n = r.ken_n;
  assign link.burstWordDone_n = r.burst_word_done_n_n;
  assign link.cycleDone_n = r.rdy_n;
  assign link.cacheFlush_n = r.flush_n;
  assign link.sysAddrOut = r.a;
  assign link.sysAddrOe = r.aOe;
  assign link.sysDataOut = r.d;
  assign busGranted = r.granted;
  assign pendingSeen = r.pend;
endmodule : bus_release_sys

//--- bus_release_props.sv
// Purpose: Link checks between processor end and system end
// Assumes: One clock, asynchronous active-low reset
// Notes: Watches interface signals only
`timescale 1ns/1ps
module bus_release_props (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic internalCyclePending,
  input wire logic busSurrenderRequest,
  input wire logic busSurrenderAck,
  input wire logic busBackoff_n,
  input wire logic addressFloatRequest,
  input wire logic snoopAddressStrobe_n,
  input wire logic cycleStart_n,
  input wire logic cpuAddrOe,
  input wire logic cpuDataOe
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  // ----------------------------------------
  // Surrender handshake
  // ----------------------------------------
  ack_float_a: assert property (busSurrenderAck |-> !cpuAddrOe && !cpuDataOe)
    else $error("acknowledge high while bus driven");
  ack_hold_a: assert property (busSurrenderAck && busSurrenderRequest |=> busSurrenderAck)
    else $error("surrender left while request held");
  ack_drop_a: assert property (busSurrenderAck && !busSurrenderRequest |=> !busSurrenderAck)
    else $error("acknowledge stayed after request low");
  ack_cause_a: assert property ($rose(busSurrenderAck) |-> $past(busSurrenderRequest))
    else $error("acknowledge without surrender request");

  // ----------------------------------------
  // Back-off and address float
  // ----------------------------------------
  bus_backoff_n_float_a: assert property (
    !busBackoff_n && !busSurrenderAck && !busSurrenderRequest |=> !cpuAddrOe && !cpuDataOe)
    else $error("bus driven during back-off");
  bus_backoff_n_resume_a: assert property ($rose(cpuAddrOe) |-> $past(busBackoff_n))
    else $error("address driven while back-off held");
  restart_a: assert property (
    $rose(busBackoff_n) && internalCyclePending |-> ##[1:3] !cycleStart_n)
    else $error("interrupted cycle not restarted");
  address_float_request_float_a: assert property (
    addressFloatRequest |=> !cpuAddrOe)
    else $error("address not released on float request");

  cover property ($rose(busSurrenderAck));
  cover property ($fell(busBackoff_n));
  cover property (!snoopAddressStrobe_n);
  cover property (!cycleStart_n);
endmodule : bus_release_props

//--- bus_release_and_snoop_control_test.sv
// Purpose: Both ends joined, driven from their user sides
// Assumes: 50 MHz clock, reset held 12 cycles
// Notes: Cache lines seen through cacheHit
`timescale 1ns/1ps
module bus_release_and_snoop_control_test;
  import bus_release_pkg::*;
  logic clock, arst_n, reqValid, reqWrite, reqCacheable, reqDone, cacheHit;
  logic wantBus, backoffHold, snoopGo, flushGo, cacheableMem, burstMode, busGranted, pendingSeen;
  addr_t reqAddr, snoopAddr;
  data_t reqData, readData, memData;
  int n_errors = 0;
  int tests_run = 0;
  logic hit;
  int starts;
  localparam addr_t LINE_A = 28'h0000a34;

  bus_release_if link();
  bus_release_cpu bus_release_cpu_i (.clock(clock), .arst_n(arst_n), .link(link.cpu),
    .reqValid(reqValid), .reqAddr(reqAddr), .reqWrite(reqWrite), .reqCacheable(reqCacheable),
    .reqData(reqData), .reqDone(reqDone), .readData(readData), .cacheHit(cacheHit));
  bus_release_sys bus_release_sys_i (.clock(clock), .arst_n(arst_n), .link(link.sys),
    .wantBus(wantBus), .backoffHold(backoffHold), .snoopGo(snoopGo), .snoopAddr(snoopAddr),
    .flushGo(flushGo), .cacheableMem(cacheableMem), .burstMode(burstMode), .memData(memData),
    .busGranted(busGranted), .pendingSeen(pendingSeen));
  bus_release_props bus_release_props_i (.clock(clock), .arst_n(arst_n),
    .internalCyclePending(link.internalCyclePending),
    .busSurrenderRequest(link.busSurrenderRequest), .busSurrenderAck(link.busSurrenderAck),
    .busBackoff_n(link.busBackoff_n), .addressFloatRequest(link.addressFloatRequest),
    .snoopAddressStrobe_n(link.snoopAddressStrobe_n), .cycleStart_n(link.cycleStart_n),
    .cpuAddrOe(link.cpuAddrOe), .cpuDataOe(link.cpuDataOe));

  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // ----------------------------------------
  // Checking and closing
  // ----------------------------------------
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    tests_run++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask : chk

  task automatic timeout;
    n_errors++;
    $display("unexpected at %0t: wait ran out", $time);
    test_done();
  endtask : timeout

  // One request; back-off held for bus_backoff_n cycles from its start, or from clock 1 to clock -bus_backoff_n when negative
  task automatic op(input addr_t a, input logic c, input int bus_backoff_n, output logic h,
    output int n);
    int k;
    logic drop;
    drop = 1'b0;
    h = 1'b0;
    n = 0;
    reqAddr <= a;
    reqCacheable <= c;
    reqValid <= 1'b1;
    backoffHold <= (bus_backoff_n > 0);
    for (k = 0; k < 80; k++)
    begin
      @(posedge clock);
      if (drop) reqValid <= 1'b0;
      if (k == bus_backoff_n || k == -bus_backoff_n) backoffHold <= 1'b0;
      if (bus_backoff_n < 0 && k == 1) backoffHold <= 1'b1;
      #1;
      if (k == 0) h = cacheHit;
      if (link.cycleStart_n === 1'b0 || cacheHit === 1'b1) drop = 1'b1;
      if (link.cycleStart_n === 1'b0) n++;
      if (reqDone === 1'b1) break;
    end
    if (k == 80) timeout();
    @(posedge clock);
    reqValid <= 1'b0;
    repeat (3) @(posedge clock);
  endtask : op

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic test_reset;
    #1;
    chk(link.busSurrenderAck, 1'b0, "ack after reset");
    chk(link.cpuAddrOe, 1'b1, "address not owned after reset");
    chk(link.internalCyclePending, 1'b0, "pending after reset");
    @(posedge clock);
    $display("reset test done");
  endtask : test_reset

  task automatic test_plain_read;
    op(LINE_A, 1'b1, 0, hit, starts);
    chk(readData, memData, "read data");
    op(LINE_A, 1'b1, 0, hit, starts);
    chk(hit, 1'b0, "line kept without cacheable input");
    reqWrite <= 1'b1;
    reqData <= 32'h3c3c0f0f;
    op(28'h0000140, 1'b0, 0, hit, starts);
    chk(link.cpuDataOut, 32'h3c3c0f0f, "write data");
    chk(link.cpuDataOe, 1'b0, "data driven after write");
    reqWrite <= 1'b0;
    $display("plain read test done");
  endtask : test_plain_read

  task automatic test_fill;
    cacheableMem <= 1'b1;
    burstMode <= 1'b1;
    @(posedge clock);
    op(LINE_A, 1'b1, 0, hit, starts);
    chk(readData, memData, "fill data");
    op(LINE_A, 1'b1, 0, hit, starts);
    chk(hit, 1'b1, "filled line missing");
    $display("fill test done");
  endtask : test_fill

  task automatic test_snoop;
    snoopAddr <= LINE_A;
    snoopGo <= 1'b1;
    @(posedge clock);
    snoopGo <= 1'b0;
    repeat (8) @(posedge clock);
    op(LINE_A, 1'b1, 0, hit, starts);
    chk(hit, 1'b0, "snooped line still valid");
    $display("snoop test done");
  endtask : test_snoop

  task automatic test_flush;
    op(LINE_A, 1'b1, 0, hit, starts);
    chk(hit, 1'b1, "refilled line missing");
    flushGo <= 1'b1;
    @(posedge clock);
    flushGo <= 1'b0;
    repeat (8) @(posedge clock);
    op(LINE_A, 1'b1, 0, hit, starts);
    chk(hit, 1'b0, "line survived flush");
    $display("flush test done");
  endtask : test_flush

  task automatic test_hold;
    int k;
    wantBus <= 1'b1;
    for (k = 0; k < 20 && busGranted !== 1'b1; k++) @(posedge clock);
    if (k == 20) timeout();
    #1;
    chk(link.busSurrenderAck, 1'b1, "no acknowledge");
    chk(link.cpuAddrOe, 1'b0, "address driven in hold");
    @(posedge clock);
    reqAddr <= 28'h0000100;
    reqCacheable <= 1'b0;
    reqValid <= 1'b1;
    repeat (4) @(posedge clock);
    #1;
    chk(link.internalCyclePending, 1'b1, "pending low in hold");
    chk(pendingSeen, 1'b1, "pending not seen");
    chk(link.busSurrenderAck, 1'b1, "hold left early");
    @(posedge clock);
    wantBus <= 1'b0;
    op(28'h0000100, 1'b0, 0, hit, starts);
    chk(starts, 1, "cycle count after hold");
    chk(link.busSurrenderAck, 1'b0, "acknowledge stuck");
    $display("hold test done");
  endtask : test_hold

  task automatic test_backoff;
    cacheableMem <= 1'b0;
    burstMode <= 1'b0;
    op(28'h0000200, 1'b0, 4, hit, starts);
    chk(starts, 2, "cycle not restarted");
    chk(readData, memData, "restarted read data");
    chk(link.busSurrenderAck, 1'b0, "ack after back-off");
    op(28'h0000300, 1'b0, -5, hit, starts);
    chk(starts, 2, "completion taken with back-off");
    $display("back-off test done");
  endtask : test_backoff

  initial
  begin
    arst_n = 1'b0;
    reqValid = 1'b0;
    reqWrite = 1'b0;
    reqCacheable = 1'b0;
    reqAddr = 28'h0000000;
    reqData = 32'h00000000;
    memData = 32'h5a5ac3c3;
    wantBus = 1'b0;
    backoffHold = 1'b0;
    snoopGo = 1'b0;
    snoopAddr = 28'h0000000;
    flushGo = 1'b0;
    cacheableMem = 1'b0;
    burstMode = 1'b0;
    repeat (12) @(posedge clock);
    arst_n <= 1'b1;
    @(posedge clock);
    test_reset();
    test_plain_read();
    test_fill();
    test_snoop();
    test_flush();
    test_hold();
    test_backoff();
    test_done();
  end
endmodule : bus_release_and_snoop_control_test
